//--- rtl/fbc_engine.sv
// Purpose: Framebuffer clears, multisample sample clears, accumulation and stencil pixel writes.
// Assumes: One command at a time; buffer-wide commands walk the 4x4 window one pixel a cycle.
// Notes: Error codes are latched until err_ack; a failing command changes nothing.
`timescale 1ns/100ps

// What this block does
// - Combined clear takes depth-stencil, index zero only.
// - Mismatched value type clears undefined, no error.
// - Per-buffer clear uses whole-clear tests and masks.
// - Bad buffer selector raises bad-selector error.
// - Bad draw-buffer index raises bad-index error.
// - Color clear in color index mode fails.
// - Color samples cleared with color buffers.
// - Depth and stencil bits clear their samples.
// - Per-buffer clear also clears its samples.
// - Accumulation pixel holds four signed components.
// - Accumulate supports exactly five operation codes.
// - Scissor limits accumulate updates to box.
// - Scaled add adds scaled read color.
// - Load overwrites with scaled read color.
// - Return scales, clamps, writes enabled color buffers.
// - Multiply scales, add offsets components in place.
// - Only return clamps; overflow elsewhere undefined.
// - Accumulate fails without buffer, binding match, RGBA.
// - Stencil pixel writes see only scissor tests.
// - Pixel stencil written through front write mask.
// - Pixel depth written when enabled; compare ignored.
// - Pixel write fails without needed buffers.
// - Stencil clear value masked to bitplanes.
// - Depth clear value clamped to unit range.
module fbc_engine
  import fbc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire fbc_cmd_t cmd,
  input wire fbc_cfg_t cfg,
  input wire logic err_ack,
  input wire logic [PIX_AW-1:0] view_addr,
  output logic cmd_ready_q,
  output logic err_pulse_q,
  output logic err_pending_q,
  output logic [1:0] err_code_q,
  output fbc_view_t view_q
);

  logic [31:0] col_q [NUM_DRAW][PIX_N];
  logic [15:0] dep_q [PIX_N];
  logic [7:0] stn_q [PIX_N];
  fbc_quad_t acc_q [PIX_N];
  logic [31:0] msc_q [PIX_N];
  logic [15:0] msd_q [PIX_N];
  logic [7:0] mss_q [PIX_N];

  fbc_state_t state_q, state_d;
  fbc_cmd_t op_q, op_d;
  logic [PIX_AW-1:0] walk_q, walk_d;
  logic cmd_ready_d;
  logic err_pulse_d, err_pending_d;
  logic [1:0] err_code_d;
  logic [1:0] err_now;
  logic accept;

  logic [PIX_AW-1:0] cur_pix;
  logic [1:0] cur_x, cur_y;
  logic in_sc;
  logic [NUM_DRAW-1:0] col_we;
  logic [31:0] col_wd [NUM_DRAW];
  logic dep_we, stn_we, acc_we, msc_we, msd_we, mss_we;
  logic [15:0] dep_wd;
  logic [7:0] stn_wd;
  fbc_quad_t acc_wd;
  logic [31:0] clr_color;
  logic [15:0] clr_depth;
  logic [7:0] clr_stencil;
  logic sel_c, sel_d, sel_s;
  fbc_quad_t alu_acc;
  logic [31:0] alu_ret;

  assign accept = cmd_valid && cmd_ready_q;

  // Command checks; any error keeps the command from being started.
  always_comb
  begin
    err_now = ERR_NONE;
    case (cmd.op)
      OP_PER_BUFFER_CLEAR:
      begin
        if (cmd.sel != SEL_COLOR && cmd.sel != SEL_DEPTH && cmd.sel != SEL_STENCIL)
          err_now = ERR_BAD_SELECTOR;
        else if (cmd.sel == SEL_COLOR && (cmd.drawbuf < 8'sh00 || cmd.drawbuf >= MAX_DRAW_BUFFERS))
          err_now = ERR_BAD_INDEX;
        else if (cmd.sel != SEL_COLOR && cmd.drawbuf != 8'sh00)
          err_now = ERR_BAD_INDEX;
        else if (cmd.sel == SEL_COLOR && cfg.color_index_mode)
          err_now = ERR_ILLEGAL_OP;
      end
      OP_COMBINED_DEPTH_STENCIL_CLEAR:
      begin
        if (cmd.sel != SEL_DEPTH_STENCIL)
          err_now = ERR_BAD_SELECTOR;
        else if (cmd.drawbuf != 8'sh00)
          err_now = ERR_BAD_INDEX;
      end
      OP_ACCUMULATE:
      begin
        if (cmd.acc_op > ACC_ADD)
          err_now = ERR_BAD_SELECTOR;
        else if (!cfg.has_accum || !cfg.fb_same || cfg.color_index_mode)
          err_now = ERR_ILLEGAL_OP;
      end
      OP_PIXEL_WRITE_COMMAND:
      begin
        if (!cfg.has_stencil || (cmd.pix_ds && !cfg.has_depth))
          err_now = ERR_ILLEGAL_OP;
      end
      default: err_now = ERR_NONE;
    endcase
  end

  always_comb
  begin
    state_d = state_q;
    op_d = op_q;
    walk_d = walk_q;
    err_pulse_d = 1'b0;
    err_pending_d = err_pending_q;
    err_code_d = err_code_q;
    if (err_ack)
    begin
      err_pending_d = 1'b0;
      err_code_d = ERR_NONE;
    end
    case (state_q)
      ST_IDLE:
      begin
        if (accept && err_now != ERR_NONE)
        begin
          // A new error wins over an acknowledge in the same cycle.
          err_pulse_d = 1'b1;
          err_pending_d = 1'b1;
          err_code_d = err_now;
        end
        else if (accept)
        begin
          op_d = cmd;
          walk_d = '0;
          state_d = ST_RUN;
        end
      end
      ST_RUN:
      begin
        walk_d = walk_q + 4'h1;
        if (op_q.op == OP_PIXEL_WRITE_COMMAND || walk_q == 4'(PIX_N - 1))
          state_d = ST_IDLE;
      end
      default: state_d = ST_IDLE;
    endcase
    cmd_ready_d = (state_d == ST_IDLE);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_q <= ST_IDLE;
      op_q <= '0;
      walk_q <= '0;
      cmd_ready_q <= 1'b0;
      err_pulse_q <= 1'b0;
      err_pending_q <= 1'b0;
      err_code_q <= ERR_NONE;
    end
    else
    begin
      state_q <= state_d;
      op_q <= op_d;
      walk_q <= walk_d;
      cmd_ready_q <= cmd_ready_d;
      err_pulse_q <= err_pulse_d;
      err_pending_q <= err_pending_d;
      err_code_q <= err_code_d;
    end
  end

  // Pixel being processed and its scissor test.
  assign cur_pix = (op_q.op == OP_PIXEL_WRITE_COMMAND) ? {op_q.pix_y, op_q.pix_x} : walk_q;
  assign cur_x = cur_pix[1:0];
  assign cur_y = cur_pix[3:2];
  assign in_sc = !cfg.scissor_en ||
                 ({1'b0, cur_x} >= cfg.sc_x && 4'({1'b0, cur_x}) < 4'(cfg.sc_x) + 4'(cfg.sc_w) &&
                  {1'b0, cur_y} >= cfg.sc_y && 4'({1'b0, cur_y}) < 4'(cfg.sc_y) + 4'(cfg.sc_h));

  fbc_accum_alu fbc_accum_alu_inst (
    .acc_op(op_q.acc_op),
    .operand(op_q.operand),
    .acc_in(acc_q[cur_pix]),
    .read_color(col_q[cfg.read_buf][cur_pix]),
    .clamp_en(cfg.clamp_en),
    .acc_out(alu_acc),
    .ret_color(alu_ret)
  );

  // Clear data for the current command, converted to storage formats.
  always_comb
  begin
    clr_color = 32'h0000_0000;
    for (int i = 0; i < 4; i++)
    begin
      if (op_q.op == OP_WHOLE_CLEAR)
        clr_color[8*i +: 8] = q_to_u8(cfg.clear_color[i]);
      else if (op_q.val_is_int || cfg.color_is_int)
        clr_color[8*i +: 8] = op_q.value[i][7:0];
      else
        clr_color[8*i +: 8] = q_to_u8(op_q.value[i]);
    end
    if (op_q.op == OP_WHOLE_CLEAR)
    begin
      clr_depth = q_to_depth(cfg.depth_clear_value);
      clr_stencil = cfg.stencil_clear_value[7:0];
    end
    else
    begin
      clr_depth = op_q.val_is_int ? op_q.value[0] : q_to_depth(op_q.value[0]);
      clr_stencil = op_q.stencil[7:0];
    end
  end

  // Which buffers the current clear aims at.
  always_comb
  begin
    sel_c = 1'b0;
    sel_d = 1'b0;
    sel_s = 1'b0;
    case (op_q.op)
      OP_WHOLE_CLEAR:
      begin
        sel_c = op_q.clear_mask[CLR_COLOR_BIT];
        sel_d = op_q.clear_mask[CLR_DEPTH_BIT];
        sel_s = op_q.clear_mask[CLR_STENCIL_BIT];
      end
      OP_PER_BUFFER_CLEAR:
      begin
        sel_c = (op_q.sel == SEL_COLOR);
        sel_d = (op_q.sel == SEL_DEPTH);
        sel_s = (op_q.sel == SEL_STENCIL);
      end
      OP_COMBINED_DEPTH_STENCIL_CLEAR:
      begin
        sel_d = 1'b1;
        sel_s = 1'b1;
      end
      default:
      begin
        sel_c = 1'b0;
      end
    endcase
  end

  // Write enables and data for one pixel of the running command.
  always_comb
  begin
    col_we = '0;
    for (int b = 0; b < NUM_DRAW; b++)
      col_wd[b] = merge_color(col_q[b][cur_pix], clr_color, cfg.color_wmask);
    dep_we = 1'b0;
    dep_wd = clr_depth;
    stn_we = 1'b0;
    stn_wd = merge_stencil(stn_q[cur_pix], clr_stencil, cfg.stencil_write_mask);
    acc_we = 1'b0;
    acc_wd = alu_acc;
    msc_we = 1'b0;
    msd_we = 1'b0;
    mss_we = 1'b0;
    if (state_q == ST_RUN && in_sc)
    begin
      case (op_q.op)
        OP_WHOLE_CLEAR, OP_PER_BUFFER_CLEAR, OP_COMBINED_DEPTH_STENCIL_CLEAR:
        begin
          for (int b = 0; b < NUM_DRAW; b++)
            col_we[b] = sel_c && cfg.draw_mask[b] &&
                        (op_q.op == OP_WHOLE_CLEAR || op_q.drawbuf == 8'(b));
          dep_we = sel_d && cfg.has_depth && cfg.depth_write_enable;
          stn_we = sel_s && cfg.has_stencil;
          // A draw target of none leaves the color samples alone.
          msc_we = cfg.has_ms && (col_we != '0);
          msd_we = cfg.has_ms && dep_we;
          mss_we = cfg.has_ms && stn_we;
          acc_we = (op_q.op == OP_WHOLE_CLEAR) && op_q.clear_mask[CLR_ACCUM_BIT] &&
                   cfg.has_accum;
          for (int i = 0; i < 4; i++)
            acc_wd[i] = clamp_q(cfg.clear_accum[i], Q_MINUS_ONE, Q_ONE);
        end
        OP_ACCUMULATE:
        begin
          if (op_q.acc_op == ACC_RETURN)
          begin
            for (int b = 0; b < NUM_DRAW; b++)
            begin
              col_we[b] = cfg.draw_mask[b];
              col_wd[b] = merge_color(col_q[b][cur_pix], alu_ret, cfg.color_wmask);
            end
          end
          else
            acc_we = 1'b1;
        end
        OP_PIXEL_WRITE_COMMAND:
        begin
          // Only the scissor test gates these writes, and depth also needs pix_ds and depth_write_enable; compare and blend are bypassed.
          stn_we = 1'b1;
          stn_wd = merge_stencil(stn_q[cur_pix], op_q.pix_stencil, cfg.stencil_write_mask);
          dep_we = op_q.pix_ds && cfg.depth_write_enable;
          dep_wd = op_q.pix_depth;
        end
        default:
        begin
          acc_we = 1'b0;
        end
      endcase
    end
  end

  // Storage arrays and the registered view port.
  always_ff @(posedge clk)
  begin
    for (int b = 0; b < NUM_DRAW; b++)
    begin
      if (col_we[b])
        col_q[b][cur_pix] <= col_wd[b];
    end
    if (dep_we)
      dep_q[cur_pix] <= dep_wd;
    if (stn_we)
      stn_q[cur_pix] <= stn_wd;
    if (acc_we)
      acc_q[cur_pix] <= acc_wd;
    if (msc_we)
      msc_q[cur_pix] <= clr_color;
    if (msd_we)
      msd_q[cur_pix] <= dep_wd;
    if (mss_we)
      mss_q[cur_pix] <= stn_wd;
    view_q <= '{color0: col_q[0][view_addr], color1: col_q[1][view_addr],
                depth: dep_q[view_addr], stencil: stn_q[view_addr], accum: acc_q[view_addr],
                ms_color: msc_q[view_addr], ms_depth: msd_q[view_addr],
                ms_stencil: mss_q[view_addr]};
  end

  property p_bad_sel;
    @(posedge clk) disable iff (rst)
    accept && cmd.op == OP_PER_BUFFER_CLEAR && cmd.sel > SEL_STENCIL
    |=> err_pulse_q && err_code_q == ERR_BAD_SELECTOR;
  endproperty
  a_bad_sel: assert property (p_bad_sel) else $error("bad selector not flagged");

  property p_ds_clear;
    @(posedge clk) disable iff (rst)
    accept && cmd.op == OP_COMBINED_DEPTH_STENCIL_CLEAR && cmd.sel == SEL_DEPTH_STENCIL &&
    cmd.drawbuf != 8'sh00 |=> err_pulse_q && err_code_q == ERR_BAD_INDEX && cmd_ready_q;
  endproperty
  a_ds_clear: assert property (p_ds_clear) else $error("combined clear index not checked");

  property p_bad_idx;
    @(posedge clk) disable iff (rst)
    accept && cmd.op == OP_PER_BUFFER_CLEAR && cmd.sel == SEL_COLOR &&
    cmd.drawbuf >= MAX_DRAW_BUFFERS |=> err_code_q == ERR_BAD_INDEX;
  endproperty
  a_bad_idx: assert property (p_bad_idx) else $error("draw buffer index not checked");

  property p_ci_mode;
    @(posedge clk) disable iff (rst)
    accept && cmd.op == OP_PER_BUFFER_CLEAR && cmd.sel == SEL_COLOR && cmd.drawbuf == 8'sh00 &&
    cfg.color_index_mode |=> err_pulse_q && err_code_q == ERR_ILLEGAL_OP;
  endproperty
  a_ci_mode: assert property (p_ci_mode) else $error("color clear in index mode accepted");

  property p_accum_err;
    @(posedge clk) disable iff (rst)
    accept && cmd.op == OP_ACCUMULATE && cmd.acc_op <= ACC_ADD && !cfg.fb_same
    |=> err_code_q == ERR_ILLEGAL_OP && cmd_ready_q;
  endproperty
  a_accum_err: assert property (p_accum_err) else $error("accumulate binding check missing");

  property p_pix_err;
    @(posedge clk) disable iff (rst)
    accept && cmd.op == OP_PIXEL_WRITE_COMMAND && !cfg.has_stencil
    |=> err_pulse_q && err_code_q == ERR_ILLEGAL_OP;
  endproperty
  a_pix_err: assert property (p_pix_err) else $error("stencil pixel write without buffer");

  property p_err_no_run;
    @(posedge clk) disable iff (rst)
    accept && err_now != ERR_NONE |=> state_q == ST_IDLE && cmd_ready_q;
  endproperty
  a_err_no_run: assert property (p_err_no_run) else $error("failing command started");

  property p_walk_len;
    @(posedge clk) disable iff (rst)
    accept && err_now == ERR_NONE && cmd.op != OP_PIXEL_WRITE_COMMAND
    |=> !cmd_ready_q ##16 cmd_ready_q;
  endproperty
  a_walk_len: assert property (p_walk_len) else $error("window walk length wrong");

  property p_pix_one;
    @(posedge clk) disable iff (rst)
    accept && err_now == ERR_NONE && cmd.op == OP_PIXEL_WRITE_COMMAND
    |=> !cmd_ready_q ##1 cmd_ready_q;
  endproperty
  a_pix_one: assert property (p_pix_one) else $error("pixel write not single cycle");

  property p_stn_mask;
    @(posedge clk) disable iff (rst)
    state_q == ST_RUN && op_q.op == OP_PIXEL_WRITE_COMMAND
    |=> ((stn_q[cur_pix] ^ $past(stn_q[cur_pix])) & ~$past(cfg.stencil_write_mask)) == 8'h00;
  endproperty
  a_stn_mask: assert property (p_stn_mask) else $error("stencil mask not honoured");

  property p_dep_keep;
    @(posedge clk) disable iff (rst)
    state_q == ST_RUN && op_q.op == OP_PIXEL_WRITE_COMMAND && !cfg.depth_write_enable
    |=> dep_q[cur_pix] == $past(dep_q[cur_pix]);
  endproperty
  a_dep_keep: assert property (p_dep_keep) else $error("depth written while disabled");

endmodule

//--- rtl/fbc_pkg.sv
// Purpose: Shared types, codes and fixed-point helpers for the framebuffer clear/accumulate block.
// Assumes: 4x4 pixel window, two color draw buffers, 8-bit unorm RGBA, 16-bit depth, 8-bit stencil.
// Notes: Accumulation, color and depth clear values are signed Q2.14 (one = 16'h4000); the stencil clear value is an integer.
package fbc_pkg;

  localparam int PIX_AW = 4;
  localparam int PIX_N = 16;
  localparam int NUM_DRAW = 2;
  localparam logic signed [7:0] MAX_DRAW_BUFFERS = 8'sh02;

  localparam logic signed [15:0] Q_ONE = 16'sh4000;
  localparam logic signed [15:0] Q_MINUS_ONE = -16'sh4000;
  localparam logic signed [15:0] Q_ZERO = 16'sh0000;

  localparam logic [2:0] OP_WHOLE_CLEAR = 3'h0;
  localparam logic [2:0] OP_PER_BUFFER_CLEAR = 3'h1;
  localparam logic [2:0] OP_COMBINED_DEPTH_STENCIL_CLEAR = 3'h2;
  localparam logic [2:0] OP_ACCUMULATE = 3'h3;
  localparam logic [2:0] OP_PIXEL_WRITE_COMMAND = 3'h4;

  localparam logic [2:0] SEL_COLOR = 3'h0;
  localparam logic [2:0] SEL_DEPTH = 3'h1;
  localparam logic [2:0] SEL_STENCIL = 3'h2;
  localparam logic [2:0] SEL_DEPTH_STENCIL = 3'h3;

  localparam logic [2:0] ACC_SCALED_ADD = 3'h0;
  localparam logic [2:0] ACC_LOAD = 3'h1;
  localparam logic [2:0] ACC_RETURN = 3'h2;
  localparam logic [2:0] ACC_MULTIPLY_OP = 3'h3;
  localparam logic [2:0] ACC_ADD = 3'h4;

  localparam int CLR_COLOR_BIT = 0;
  localparam int CLR_ACCUM_BIT = 1;
  localparam int CLR_DEPTH_BIT = 2;
  localparam int CLR_STENCIL_BIT = 3;

  localparam logic [1:0] ERR_NONE = 2'h0;
  localparam logic [1:0] ERR_BAD_SELECTOR = 2'h1;
  localparam logic [1:0] ERR_BAD_INDEX = 2'h2;
  localparam logic [1:0] ERR_ILLEGAL_OP = 2'h3;

  typedef logic [3:0][15:0] fbc_quad_t;

  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_RUN = 2'b10} fbc_state_t;

  typedef struct packed {
    logic [2:0] op;
    logic [2:0] sel;
    logic signed [7:0] drawbuf;
    logic val_is_int;
    fbc_quad_t value;
    logic [31:0] stencil;
    logic [2:0] acc_op;
    logic signed [15:0] operand;
    logic [3:0] clear_mask;
    logic [1:0] pix_x;
    logic [1:0] pix_y;
    logic pix_ds;
    logic [15:0] pix_depth;
    logic [7:0] pix_stencil;
  } fbc_cmd_t;

  typedef struct packed {
    logic color_index_mode;
    logic scissor_en;
    logic [2:0] sc_x;
    logic [2:0] sc_y;
    logic [2:0] sc_w;
    logic [2:0] sc_h;
    logic has_accum;
    logic has_depth;
    logic has_stencil;
    logic has_ms;
    logic fb_same;
    logic [1:0] draw_mask;
    logic read_buf;
    logic color_is_int;
    logic [3:0] color_wmask;
    logic [7:0] stencil_write_mask;
    logic depth_write_enable;
    logic clamp_en;
    fbc_quad_t clear_color;
    logic signed [15:0] depth_clear_value;
    logic [31:0] stencil_clear_value;
    fbc_quad_t clear_accum;
  } fbc_cfg_t;

  typedef struct packed {
    logic [31:0] color0;
    logic [31:0] color1;
    logic [15:0] depth;
    logic [7:0] stencil;
    fbc_quad_t accum;
    logic [31:0] ms_color;
    logic [15:0] ms_depth;
    logic [7:0] ms_stencil;
  } fbc_view_t;

  function automatic logic signed [15:0] sat_q(input logic signed [31:0] v);
    if (v > 32'sh00007FFF)
      return 16'sh7FFF;
    else if (v < -32'sh00008000)
      return 16'sh8000;
    return v[15:0];
  endfunction

  function automatic logic signed [15:0] clamp_q(input logic signed [15:0] v,
                                                 input logic signed [15:0] lo,
                                                 input logic signed [15:0] hi);
    if (v < lo)
      return lo;
    else if (v > hi)
      return hi;
    return v;
  endfunction

  // Unit-range clamp then conversion to an 8-bit unsigned normalized component.
  function automatic logic [7:0] q_to_u8(input logic signed [15:0] v);
    logic signed [15:0] c;
    c = clamp_q(v, Q_ZERO, Q_ONE);
    return (c == Q_ONE) ? 8'hFF : c[13:6];
  endfunction

  function automatic logic signed [15:0] u8_to_q(input logic [7:0] c);
    return {2'b00, c, c[7:2]};
  endfunction

  function automatic logic [15:0] q_to_depth(input logic signed [15:0] v);
    logic signed [15:0] c;
    c = clamp_q(v, Q_ZERO, Q_ONE);
    return (c == Q_ONE) ? 16'hFFFF : {c[13:0], 2'b00};
  endfunction

  function automatic logic [31:0] merge_color(input logic [31:0] old_c, input logic [31:0] new_c,
                                              input logic [3:0] mask);
    logic [31:0] r;
    r = old_c;
    for (int i = 0; i < 4; i++)
    begin
      if (mask[i])
        r[8*i +: 8] = new_c[8*i +: 8];
    end
    return r;
  endfunction

  function automatic logic [7:0] merge_stencil(input logic [7:0] old_s, input logic [7:0] new_s,
                                               input logic [7:0] mask);
    return (old_s & ~mask) | (new_s & mask);
  endfunction

endpackage

//--- rtl/fbc_accum_alu.sv
// Purpose: Per-pixel accumulation arithmetic for the five accumulate operations.
// Assumes: Accumulation components are signed Q2.14; color is 8-bit unorm RGBA.
// Notes: Purely combinational; the caller registers all results.
`timescale 1ns/100ps
module fbc_accum_alu
  import fbc_pkg::*;
(
  input wire logic [2:0] acc_op,
  input wire logic signed [15:0] operand,
  input wire fbc_quad_t acc_in,
  input wire logic [31:0] read_color,
  input wire logic clamp_en,
  output fbc_quad_t acc_out,
  output logic [31:0] ret_color
);

  logic signed [31:0] scaled;
  logic signed [31:0] prod;
  logic signed [31:0] sum;
  logic signed [15:0] ret_v;

  always_comb
  begin
    acc_out = acc_in;
    ret_color = 32'h0000_0000;
    scaled = 32'sh0;
    prod = 32'sh0;
    sum = 32'sh0;
    ret_v = 16'sh0;
    for (int i = 0; i < 4; i++)
    begin
      // Fixed-point read color is taken as unorm in [0,1] before scaling.
      scaled = u8_to_q(read_color[8*i +: 8]) * operand;
      prod = $signed(acc_in[i]) * operand;
      sum = $signed(acc_in[i]) + operand;
      ret_v = sat_q(prod >>> 14);
      case (acc_op)
        ACC_SCALED_ADD: acc_out[i] = sat_q($signed(acc_in[i]) + (scaled >>> 14));
        ACC_LOAD: acc_out[i] = sat_q(scaled >>> 14);
        ACC_MULTIPLY_OP: acc_out[i] = sat_q(prod >>> 14);
        ACC_ADD: acc_out[i] = sat_q(sum);
        default: acc_out[i] = acc_in[i];
      endcase
      // Only return clamps, and only with clamp_en set; otherwise its out-of-range values wrap, while the other operations saturate.
      ret_color[8*i +: 8] = clamp_en ? q_to_u8(ret_v) : ret_v[13:6];
    end
  end

endmodule

//--- tb/fbc_host_model.sv
// Purpose: Host side that offers one command at a time.
// Assumes: A command is taken on an edge with valid and ready high.
// Notes: Command lines scramble while nothing is offered.
`timescale 1ns/100ps
module fbc_host_model
  import fbc_pkg::*;
(
  input wire logic clk,
  input wire logic go,
  input wire fbc_cmd_t next_cmd,
  input wire logic cmd_ready_q,
  output logic cmd_valid,
  output fbc_cmd_t cmd
);
  initial
  begin
    cmd_valid = 1'b0;
    cmd = '0;
  end
  always @(posedge clk)
  begin
    if (cmd_valid && cmd_ready_q)
    begin
      cmd_valid <= 1'b0;
      cmd <= ~cmd;
    end
    else if (!cmd_valid && go)
    begin
      cmd_valid <= 1'b1;
      cmd <= next_cmd;
    end
  end
endmodule

//--- tb/fbc_engine_test.sv
// Purpose: Self-checking bench for the clear and pixel write engine.
// Assumes: 100 MHz clock, synchronous active-high reset.
// Notes: Expected values queue up and a watcher compares them.
`timescale 1ns/100ps
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin error_cnt++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module fbc_engine_test
  import fbc_pkg::*;
;
  logic clk, rst, go, hv, vl, err_ack, rdy, ep, epend;
  logic [PIX_AW-1:0] view_addr;
  fbc_cmd_t nc, hc, c, ac;
  fbc_cfg_t cfg;
  logic [1:0] ec, ee;
  fbc_view_t vq;
  int error_cnt, checks, cyc;
  logic [1:0] eq[$];
  logic [63:0] xq[$];
  logic [1:0] fq[$];
  logic [63:0] xe;
  logic [47:0] pw;
  logic [1:0] fe;
  logic [7:0] r;

  fbc_host_model fbc_host_model_inst (.clk(clk), .go(go), .next_cmd(nc), .cmd_ready_q(rdy),
    .cmd_valid(hv), .cmd(hc));
  fbc_engine fbc_engine_inst (.clk(clk), .rst(rst), .cmd_valid(hv), .cmd(hc), .cfg(cfg),
    .err_ack(err_ack), .view_addr(view_addr), .cmd_ready_q(rdy), .err_pulse_q(ep),
    .err_pending_q(epend), .err_code_q(ec), .view_q(vq));

  function automatic fbc_cmd_t mk(logic [2:0] op, logic [2:0] sel, logic signed [7:0] db);
    mk = '0;
    mk.op = op;
    mk.sel = sel;
    mk.drawbuf = db;
  endfunction

  task automatic send(fbc_cmd_t k);
    @(posedge clk) nc <= k;
    go <= 1'b1;
    @(posedge clk) go <= 1'b0;
    for (int i = 0; i < 40; i++)
    begin
      @(posedge clk);
      #1;
      if (!hv && rdy === 1'b1)
        break;
      if (i == 39)
        error_cnt++;
    end
  endtask

  task automatic bad(fbc_cmd_t k, logic [1:0] code);
    eq.push_back(code);
    send(k);
  endtask

  task automatic look(logic [3:0] a, logic [1:0] f, logic [63:0] e);
    fq.push_back(f);
    xq.push_back(e);
    @(posedge clk) view_addr <= a;
    @(posedge clk) vl <= 1'b1;
    @(posedge clk) vl <= 1'b0;
  endtask

  task automatic end_sim();
    error_cnt += eq.size() + xq.size();
    if (error_cnt == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Results are read mid-cycle so that they have settled.
  always @(negedge clk)
  begin
    if (ep === 1'b1)
    begin
      ee = eq.pop_front();
      `CHK("err_code", ee, ec)
      `CHK("err_pending", 1'b1, epend)
    end
    if (vl)
    begin
      xe = xq.pop_front();
      fe = fq.pop_front();
      case (fe)
        2'h0: `CHK("view_ds", xe, {16'h0, vq.depth, vq.stencil, vq.ms_depth, vq.ms_stencil})
        2'h1: `CHK("view_color", xe, {vq.color0, vq.color1})
        2'h2: `CHK("view_accum", xe, vq.accum)
        default: `CHK("view_ms_err", xe, {vq.ms_color, 29'h0, epend, ec})
      endcase
    end
  end

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      error_cnt++;
      end_sim();
    end
  end

  initial
  begin
    rst = 1'b1;
    go = 1'b0;
    vl = 1'b0;
    err_ack = 1'b0;
    view_addr = '0;
    nc = '0;
    cyc = 0;
    error_cnt = 0;
    checks = 0;
    cfg = '0;
    cfg.has_accum = 1'b1;
    cfg.has_depth = 1'b1;
    cfg.has_stencil = 1'b1;
    cfg.has_ms = 1'b1;
    cfg.fb_same = 1'b1;
    cfg.draw_mask = 2'h3;
    cfg.color_wmask = 4'hF;
    cfg.stencil_write_mask = 8'hFF;
    cfg.depth_write_enable = 1'b1;
    void'($urandom(32'hC410));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    c = mk(OP_COMBINED_DEPTH_STENCIL_CLEAR, SEL_DEPTH_STENCIL, 8'sh00);
    c.value[0] = 16'h7000;
    c.stencil = 32'h123456AB;
    send(c);
    look(4'h9, 2'h0, 64'hFFFFABFFFFAB);
    r = 8'($urandom());
    @(posedge clk) cfg.stencil_write_mask <= 8'h0F;
    c = mk(OP_PIXEL_WRITE_COMMAND, SEL_COLOR, 8'sh00);
    c.pix_x = 2'h1;
    c.pix_y = 2'h2;
    c.pix_ds = 1'b1;
    c.pix_depth = 16'h1234;
    c.pix_stencil = r;
    send(c);
    pw = {16'h1234, 8'hA0 | (r & 8'h0F), 24'hFFFFAB};
    look(4'h9, 2'h0, {16'h0, pw});
    @(posedge clk) cfg.depth_write_enable <= 1'b0;
    c.pix_depth = 16'h5555;
    send(c);
    look(4'h9, 2'h0, {16'h0, pw});
    @(posedge clk) cfg.depth_write_enable <= 1'b1;
    cfg.clear_color <= {16'shC000, 16'sh2000, Q_ZERO, Q_ONE};
    cfg.clear_accum <= {4{16'sh2000}};
    ac = mk(OP_WHOLE_CLEAR, SEL_COLOR, 8'sh00);
    ac.clear_mask = 4'h3;
    send(ac);
    look(4'h9, 2'h1, {2{32'h008000FF}});
    @(posedge clk) cfg.scissor_en <= 1'b1;
    cfg.sc_x <= 3'h1;
    cfg.sc_y <= 3'h1;
    cfg.sc_w <= 3'h2;
    cfg.sc_h <= 3'h2;
    cfg.clamp_en <= 1'b1;
    ac = mk(OP_ACCUMULATE, SEL_COLOR, 8'sh00);
    ac.acc_op = ACC_LOAD;
    ac.operand = Q_ONE;
    send(ac);
    look(4'h9, 2'h2, 64'h0000_2020_0000_3FFF);
    look(4'h0, 2'h2, {4{16'h2000}});
    ac.acc_op = ACC_ADD;
    ac.operand = 16'shF000;
    send(ac);
    look(4'h9, 2'h2, 64'hF000_1020_F000_2FFF);
    ac.acc_op = ACC_MULTIPLY_OP;
    ac.operand = 16'sh2000;
    send(ac);
    ac.acc_op = ACC_RETURN;
    ac.operand = Q_ONE;
    send(ac);
    look(4'h9, 2'h1, {2{32'h0020005F}});
    look(4'h0, 2'h1, {2{32'h008000FF}});
    bad(mk(OP_PER_BUFFER_CLEAR, SEL_DEPTH_STENCIL, 8'sh00), ERR_BAD_SELECTOR);
    bad(mk(OP_COMBINED_DEPTH_STENCIL_CLEAR, SEL_DEPTH, 8'sh00), ERR_BAD_SELECTOR);
    bad(mk(OP_PER_BUFFER_CLEAR, SEL_COLOR, MAX_DRAW_BUFFERS), ERR_BAD_INDEX);
    bad(mk(OP_PER_BUFFER_CLEAR, SEL_COLOR, -8'sh01), ERR_BAD_INDEX);
    bad(mk(OP_PER_BUFFER_CLEAR, SEL_STENCIL, 8'sh01), ERR_BAD_INDEX);
    bad(mk(OP_COMBINED_DEPTH_STENCIL_CLEAR, SEL_DEPTH_STENCIL, 8'sh01), ERR_BAD_INDEX);
    @(posedge clk) cfg.fb_same <= 1'b0;
    bad(mk(OP_ACCUMULATE, SEL_COLOR, 8'sh00), ERR_ILLEGAL_OP);
    @(posedge clk) cfg.fb_same <= 1'b1;
    cfg.color_index_mode <= 1'b1;
    bad(mk(OP_PER_BUFFER_CLEAR, SEL_COLOR, 8'sh00), ERR_ILLEGAL_OP);
    bad(mk(OP_ACCUMULATE, SEL_COLOR, 8'sh00), ERR_ILLEGAL_OP);
    @(posedge clk) cfg.color_index_mode <= 1'b0;
    cfg.has_stencil <= 1'b0;
    bad(c, ERR_ILLEGAL_OP);
    look(4'h9, 2'h0, {16'h0, pw});
    look(4'h9, 2'h3, {32'h008000FF, 29'h0, 1'b1, ERR_ILLEGAL_OP});
    @(posedge clk) err_ack <= 1'b1;
    @(posedge clk) err_ack <= 1'b0;
    look(4'h9, 2'h3, {32'h008000FF, 29'h0, 1'b0, ERR_NONE});
    repeat (3) @(posedge clk);
    end_sim();
  end
endmodule
